//--- rtl/t1c_pkg.sv
`default_nettype none
package t1c_pkg;

  // ----------------------------------------
  // line and stream figures
  // ----------------------------------------
  localparam int unsigned LINE_RATE_BPS = 1544000;
  localparam int unsigned WORD_BITS     = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned SUB_LEN       = 8;

  // ----------------------------------------
  // substitute slots, counted from the first zero
  // ----------------------------------------
  localparam logic [2:0] SLOT_V1   = 3'h3;
  localparam logic [2:0] SLOT_B1   = 3'h4;
  localparam logic [2:0] SLOT_V2   = 3'h6;
  localparam logic [2:0] SLOT_B2   = 3'h7;
  localparam logic [2:0] SLOT_LAST = 3'h7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic       RST_POL   = 1'b0;
  localparam logic [2:0] RST_CNT   = 3'h0;

  typedef enum logic [1:0] {
    T1C_SEND  = 2'b01,
    T1C_SUBST = 2'b10
  } t1c_enc_type;

endpackage
`default_nettype wire

//--- rtl/t1c_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module t1c_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  // drain side
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_q];
  assign cnt_d    = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_q      <= wr_q + AW'(push);
      rd_q      <= rd_q + AW'(pop);
      cnt_q     <= cnt_d;
      // flags kept as flops so the ports come straight from registers
      in_ready  <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/t1c_codec.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - line side runs one bit per line clock, nominally 1.544 Mb/s
// - configuration input picks plain AMI or B8ZS line code
// - AMI: ones alternate pulse polarity, zeros send no pulse
// - B8ZS encoder replaces each eight-zero run with a violating substitute
// - B8ZS decoder recognises substitutes after the first received mark since reset and restores the eight zeros
// - stream is unframed; every bit passes untouched, no alignment
// - transmit line is clocked by this channel's line clock, not the system clock of the stream
// - each channel instance has its own clocks, no shared timing
module t1c_codec #(
  parameter int unsigned WIDTH = t1c_pkg::WORD_BITS,
  parameter int unsigned DEPTH = t1c_pkg::FIFO_DEPTH
) (
  // system side clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // line clock of this channel
  input  wire logic             line_clk,
  // configuration
  input  wire logic             code_b8zs,
  // stream towards the line
  input  wire logic [WIDTH-1:0] tx_word,
  input  wire logic             tx_valid,
  output var  logic             tx_ready,
  // stream from the line
  output var  logic [WIDTH-1:0] rx_word_q,
  output var  logic             rx_valid_q,
  output var  logic             rx_code_err_q,
  // bipolar line
  output var  logic             line_tx_pos_q,
  output var  logic             line_tx_neg_q,
  input  wire logic             line_rx_pos,
  input  wire logic             line_rx_neg
);
  localparam int unsigned CW = $clog2(WIDTH);

  initial
  begin
    if (WIDTH < 4 || (1 << CW) != WIDTH)
      $error("word width must be a power of two, at least 4");
  end

  function automatic logic is_pulse(input logic p, input logic n,
                                    input logic pol);
    is_pulse = pol ? (p & ~n) : (n & ~p);
  endfunction

  // ----------------------------------------
  // system domain: buffer and crossings
  // ----------------------------------------
  logic [WIDTH-1:0] f_data;
  logic             f_valid;
  logic             pop;
  logic             req_s1_q, req_s2_q, req_s3_q;
  logic             rxt_s1_q, rxt_s2_q, rxt_s3_q;
  logic [WIDTH-1:0] hold_q;
  logic             ack_q;
  logic             req_ev;
  logic             rxt_ev;
  logic             req_q;
  logic             rxt_q;
  logic [WIDTH-1:0] lw_q;
  logic             lerr_q;

  t1c_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  assign req_ev = req_s2_q ^ req_s3_q;
  assign rxt_ev = rxt_s2_q ^ rxt_s3_q;
  assign pop    = req_ev & f_valid;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
      {rxt_s1_q, rxt_s2_q, rxt_s3_q} <= 3'h0;
    end
    else
    begin
      {req_s1_q, req_s2_q, req_s3_q} <= {req_q, req_s1_q, req_s2_q};
      {rxt_s1_q, rxt_s2_q, rxt_s3_q} <= {rxt_q, rxt_s1_q, rxt_s2_q};
    end
  end

  // underrun sends all zeros; the line never stops
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_q <= '0;
      ack_q  <= 1'b0;
    end
    else if (req_ev)
    begin
      hold_q <= f_valid ? f_data : '0;
      ack_q  <= ~ack_q;
    end
  end

  // line words are held a whole word time, so one toggle carries them
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_word_q     <= '0;
      rx_valid_q    <= 1'b0;
      rx_code_err_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rxt_ev;
      if (rxt_ev)
      begin
        rx_word_q     <= lw_q;
        rx_code_err_q <= lerr_q;
      end
    end
  end

  // ----------------------------------------
  // line domain: synchronisers
  // ----------------------------------------
  logic m_s1_q, m_s2_q;
  logic p_s1_q, p_s2_q, n_s1_q, n_s2_q;
  logic a_s1_q, a_s2_q, a_s3_q;
  logic ack_ev;

  assign ack_ev = a_s2_q ^ a_s3_q;

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {m_s1_q, m_s2_q}         <= 2'h0;
      {p_s1_q, p_s2_q}         <= 2'h0;
      {n_s1_q, n_s2_q}         <= 2'h0;
      {a_s1_q, a_s2_q, a_s3_q} <= 3'h0;
    end
    else
    begin
      {m_s1_q, m_s2_q}         <= {code_b8zs, m_s1_q};
      {p_s1_q, p_s2_q}         <= {line_rx_pos, p_s1_q};
      {n_s1_q, n_s2_q}         <= {line_rx_neg, n_s1_q};
      {a_s1_q, a_s2_q, a_s3_q} <= {ack_q, a_s1_q, a_s2_q};
    end
  end

  // ----------------------------------------
  // line domain: transmit word to bits
  // ----------------------------------------
  logic [CW-1:0]    tcnt_q;
  logic [WIDTH-1:0] pend_q;
  logic [WIDTH-1:0] tsh_q;
  logic [7:0]       la_q;
  logic             tload;

  assign tload = tcnt_q == CW'(WIDTH-1);

  // bit timing is the line clock itself, never the system clock
  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tcnt_q <= '0;
      req_q  <= 1'b0;
    end
    else
    begin
      tcnt_q <= tcnt_q + CW'(1);
      if (tcnt_q == '0)
        req_q <= ~req_q;
    end
  end

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_q <= '0;
    else if (ack_ev)
      pend_q <= hold_q;
    else if (tload)
      pend_q <= '0;
  end

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tsh_q <= '0;
      la_q  <= 8'h00;
    end
    else
    begin
      tsh_q <= tload ? pend_q : {tsh_q[WIDTH-2:0], 1'b0};
      // eight bits of look-ahead for the zero-run test
      la_q  <= {la_q[6:0], tsh_q[WIDTH-1]};
    end
  end

  // ----------------------------------------
  // line domain: encoder
  // ----------------------------------------
  t1c_pkg::t1c_enc_type st_q;
  logic [2:0]           scnt_q;
  logic                 tpol_q;
  logic                 sub_go;
  logic                 slot_p;
  logic                 slot_n;

  assign sub_go = m_s2_q && la_q == 8'h00;

  always_comb
  begin
    slot_p = 1'b0;
    slot_n = 1'b0;
    case (scnt_q)
      t1c_pkg::SLOT_V1,
      t1c_pkg::SLOT_B2:
      begin
        slot_p = tpol_q;
        slot_n = ~tpol_q;
      end
      t1c_pkg::SLOT_B1,
      t1c_pkg::SLOT_V2:
      begin
        slot_p = ~tpol_q;
        slot_n = tpol_q;
      end
      default:
      begin
        slot_p = 1'b0;
        slot_n = 1'b0;
      end
    endcase
  end

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q          <= t1c_pkg::T1C_SEND;
      scnt_q        <= t1c_pkg::RST_CNT;
      tpol_q        <= t1c_pkg::RST_POL;
      line_tx_pos_q <= 1'b0;
      line_tx_neg_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        t1c_pkg::T1C_SEND:
        begin
          if (sub_go)
          begin
            st_q          <= t1c_pkg::T1C_SUBST;
            scnt_q        <= 3'h1;
            line_tx_pos_q <= 1'b0;
            line_tx_neg_q <= 1'b0;
          end
          else
          begin
            // one: opposite of the last pulse; zero: no pulse
            line_tx_pos_q <= la_q[7] & ~tpol_q;
            line_tx_neg_q <= la_q[7] & tpol_q;
            if (la_q[7])
              tpol_q <= ~tpol_q;
          end
        end
        t1c_pkg::T1C_SUBST:
        begin
          // last substitute pulse equals the prior one, polarity unchanged
          line_tx_pos_q <= slot_p;
          line_tx_neg_q <= slot_n;
          scnt_q        <= scnt_q + 3'h1;
          if (scnt_q == t1c_pkg::SLOT_LAST)
            st_q <= t1c_pkg::T1C_SEND;
        end
        default:
          st_q <= t1c_pkg::T1C_SEND;
      endcase
    end
  end

  // ----------------------------------------
  // line domain: decoder
  // ----------------------------------------
  logic [7:0]       sp_q;
  logic [7:0]       sn_q;
  logic             rpol_q;
  logic             seen_q;
  logic             match;
  logic             ex_bit;
  logic             ex_err;
  logic [CW-1:0]    rcnt_q;
  logic [WIDTH-1:0] rsh_q;
  logic             racc_q;

  // window indices 7..0 hold slots 1..8 of a candidate substitute
  assign match = m_s2_q && seen_q
               && (sp_q[7:5] | sn_q[7:5]) == 3'h0
               && !(sp_q[2] | sn_q[2])
               && is_pulse(sp_q[4], sn_q[4], rpol_q)
               && is_pulse(sp_q[3], sn_q[3], ~rpol_q)
               && is_pulse(sp_q[1], sn_q[1], ~rpol_q)
               && is_pulse(sp_q[0], sn_q[0], rpol_q);

  assign ex_bit = sp_q[7] | sn_q[7];
  // substitutes are cleared before exit, so any repeat here is an error
  assign ex_err = (sp_q[7] & sn_q[7])
                | (seen_q & sp_q[7] & rpol_q)
                | (seen_q & sn_q[7] & ~rpol_q);

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sp_q <= 8'h00;
      sn_q <= 8'h00;
    end
    else if (match)
    begin
      sp_q <= {7'h00, p_s2_q};
      sn_q <= {7'h00, n_s2_q};
    end
    else
    begin
      sp_q <= {sp_q[6:0], p_s2_q};
      sn_q <= {sn_q[6:0], n_s2_q};
    end
  end

  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rpol_q <= t1c_pkg::RST_POL;
      seen_q <= 1'b0;
    end
    else if (ex_bit)
    begin
      rpol_q <= sp_q[7];
      seen_q <= 1'b1;
    end
  end

  // no frame search: words are cut at arbitrary bit positions
  always_ff @(posedge line_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rcnt_q <= '0;
      rsh_q  <= '0;
      racc_q <= 1'b0;
      lw_q   <= '0;
      lerr_q <= 1'b0;
      rxt_q  <= 1'b0;
    end
    else
    begin
      rcnt_q <= rcnt_q + CW'(1);
      rsh_q  <= {rsh_q[WIDTH-2:0], ex_bit};
      racc_q <= (rcnt_q == CW'(WIDTH-1)) ? 1'b0 : (racc_q | ex_err);
      if (rcnt_q == CW'(WIDTH-1))
      begin
        lw_q   <= {rsh_q[WIDTH-2:0], ex_bit};
        lerr_q <= racc_q | ex_err;
        rxt_q  <= ~rxt_q;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/t1c_codec_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// line and stream checks
// ---
module t1c_codec_sva #(
  parameter int unsigned WIDTH = 8
) (
  // clocks and reset
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  input wire logic             line_clk,
  // stream side
  input wire logic             code_b8zs,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic [WIDTH-1:0] rx_word_q,
  input wire logic             rx_valid_q,
  input wire logic             rx_code_err_q,
  // line side
  input wire logic             line_tx_pos_q,
  input wire logic             line_tx_neg_q,
  input wire logic             line_rx_pos,
  input wire logic             line_rx_neg
);
  logic       last_q, seen_q, mode_q, pulse, viol, calm;
  logic [3:0] gap_q;
  logic [5:0] stab_q;
  assign pulse = line_tx_pos_q | line_tx_neg_q;
  assign viol  = seen_q & pulse & (line_tx_pos_q == last_q);
  assign calm  = stab_q == 6'h3f;
  // a mode change leaves look-ahead in flight, so wait it out
  always_ff @(posedge line_clk or posedge sys_rst)
    if (sys_rst)
      {last_q, seen_q, mode_q, gap_q, stab_q} <= '0;
    else
    begin
      mode_q <= code_b8zs;
      stab_q <= mode_q != code_b8zs ? 6'h0 : stab_q + {5'h0, !calm};
      gap_q  <= pulse ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
      if (pulse)
      begin
        last_q <= line_tx_pos_q;
        seen_q <= 1'b1;
      end
    end
  a_marks_apart:
    assert property (@(posedge line_clk) disable iff (sys_rst)
      !(line_tx_pos_q && line_tx_neg_q)) else $error("double mark");
  a_ami_alternate:
    assert property (@(posedge line_clk) disable iff (sys_rst)
      calm && !code_b8zs |-> !viol) else $error("ami violation");
  a_zero_runs:
    assert property (@(posedge line_clk) disable iff (sys_rst)
      calm && code_b8zs && seen_q |-> gap_q < 4'h8)
      else $error("eight empty slots");
  a_subst_shape:
    assert property (@(posedge line_clk) disable iff (sys_rst)
      calm && code_b8zs && viol |-> (gap_q == 4'h3 || gap_q == 4'h1)
      ##1 (pulse && line_tx_pos_q != last_q)) else $error("bad substitute");
  a_word_gap:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      rx_valid_q |=> !rx_valid_q [*8]) else $error("words too close");
  a_word_hold:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      !rx_valid_q |-> $stable(rx_word_q) && $stable(rx_code_err_q))
      else $error("word moved");
  a_ready_back:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      !tx_ready |-> ##[1:40] tx_ready) else $error("line not draining");
  a_err_flag:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      line_rx_pos && line_rx_neg |-> ##[1:80] rx_valid_q && rx_code_err_q)
      else $error("violation not flagged");
  c_subst: cover property (@(posedge line_clk) viol && code_b8zs);
  c_refuse: cover property (@(posedge sys_clk) tx_valid && !tx_ready);
  c_err: cover property (@(posedge sys_clk) rx_valid_q && rx_code_err_q);
endmodule
bind t1c_codec t1c_codec_sva #(.WIDTH(WIDTH)) chk_u (
  .sys_clk, .sys_rst, .line_clk, .code_b8zs, .tx_valid, .tx_ready,
  .rx_word_q, .rx_valid_q, .rx_code_err_q, .line_tx_pos_q,
  .line_tx_neg_q, .line_rx_pos, .line_rx_neg);
`default_nettype wire

//--- bench/t1c_line_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// far-end equipment: loops the line back
// ---
module t1c_line_peer (
  // clock and reset
  input  wire logic line_clk,
  input  wire logic rst,
  // marks from the codec, fault request
  input  wire logic tx_pos,
  input  wire logic tx_neg,
  input  wire logic inj,
  // marks towards the codec
  output var  logic rx_pos_q,
  output var  logic rx_neg_q
);
  // echoes the code it is sent; a request forces a double mark
  always_ff @(posedge line_clk or posedge rst)
    if (rst)
      {rx_pos_q, rx_neg_q} <= 2'h0;
    else
      {rx_pos_q, rx_neg_q} <= {tx_pos, tx_neg} | {2{inj}};
endmodule
`default_nettype wire

//--- bench/t1c_codec_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// stream round trip over a looped line
// ---
module t1c_codec_bench;
  logic sys_clk = 1'b0, line_clk = 1'b0, sys_rst = 1'b1;
  logic code_b8zs = 1'b1, tx_valid = 1'b0, inj = 1'b0;
  logic [7:0] tx_word = 8'h00, rx_word_q;
  logic tx_ready, rx_valid_q, rx_code_err_q;
  logic line_tx_pos_q, line_tx_neg_q, line_rx_pos, line_rx_neg;
  logic [31:0] seed = 32'h50;
  logic [7:0] corner [8] = '{8'h00, 8'h00, 8'hff, 8'h80, 8'hff, 8'h01,
                             8'h00, 8'hc3};
  int fails = 0, checked = 0, errs = 0, acc, ref_at;
  bit txq[$], rxq[$];
  always #5 sys_clk = ~sys_clk;
  always #7.5 line_clk = ~line_clk;
  t1c_codec dut_u (.sys_clk, .sys_rst, .line_clk, .code_b8zs, .tx_word,
    .tx_valid, .tx_ready, .rx_word_q, .rx_valid_q, .rx_code_err_q,
    .line_tx_pos_q, .line_tx_neg_q, .line_rx_pos, .line_rx_neg);
  t1c_line_peer peer_u (.line_clk, .rst(sys_rst), .tx_pos(line_tx_pos_q),
    .tx_neg(line_tx_neg_q), .inj, .rx_pos_q(line_rx_pos),
    .rx_neg_q(line_rx_neg));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // word boundary is arbitrary, so look for the sent bits anywhere
  function automatic logic found();
    int k;
    for (int o = 0; o + txq.size() <= rxq.size(); o++)
    begin
      for (k = 0; k < txq.size() && rxq[o+k] == txq[k]; k++);
      if (k == txq.size())
        return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(negedge sys_clk)
    if (rx_valid_q === 1'b1)
    begin
      for (int i = 7; i >= 0; i--)
        rxq.push_back(rx_word_q[i]);
      if (rx_code_err_q !== 1'b0)
        errs++;
    end
  task automatic send(input logic [7:0] w);
    #1;
    tx_valid = 1'b1;
    tx_word = w;
    for (int i = 7; i >= 0; i--)
      txq.push_back(w[i]);
    if (tx_ready !== 1'b1 && ref_at < 0)
      ref_at = acc;
    while (tx_ready !== 1'b1)
      @(posedge sys_clk) #1;
    @(posedge sys_clk);
    acc++;
  endtask
  task automatic run(input logic mode);
    #1;
    code_b8zs = mode;
    repeat (200) @(posedge sys_clk);
    txq.delete();
    rxq.delete();
    {errs, acc, ref_at} = {32'd0, 32'd0, -32'sd1};
    foreach (corner[i])
      send(corner[i]);
    repeat (16)
    begin
      seed = xs(seed);
      send(seed[7:0]);
    end
    #1;
    tx_valid = 1'b0;
    for (int n = 0; n < 300 && !found(); n++)
      repeat (10) @(posedge sys_clk);
    check("stream", found(), 1);
    check("errors", errs, 0);
    // signed compare, so a buffer that never fills cannot pass
    check("fill", ref_at >= int'(t1c_pkg::FIFO_DEPTH)
      && ref_at <= 20, 1);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #700000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    run(1'b1);
    @(posedge line_clk) #1 inj = 1'b1;
    @(posedge line_clk) #1 inj = 1'b0;
    repeat (100) @(posedge sys_clk);
    check("flagged", errs > 0, 1);
    run(1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
